//--- verilog/dos_pkg.sv
// Constants for the loop operating-status register block.
// Assumes a single 20 MHz system clock and a byte-wide register port.
package dos_pkg;
  localparam logic [7:0] DOS_ADDR_OPERATING_STATE_STATUS = 8'h09;
  localparam int DOS_BIT_SYNC2K = 7;
  localparam int DOS_BIT_AUX_LOCKED = 6;
  localparam int DOS_BIT_MAIN_SOFT_ALARM = 5;
  localparam int DOS_BIT_AUX_SOFT_ALARM = 4;
  localparam int DOS_BIT_UNUSED = 3;
  localparam int DOS_FSM_MSB = 2;
  localparam int DOS_FSM_LSB = 0;
  localparam logic [7:0] DOS_RESET_VALUE = 8'h41;
  localparam logic [2:0] DOS_MODE_FREE_RUN = 3'h1;
  localparam logic [2:0] DOS_MODE_HOLDOVER = 3'h2;
  localparam logic [2:0] DOS_MODE_LOCKED = 3'h4;
  localparam logic [2:0] DOS_MODE_PRE_LOCKED2 = 3'h5;
  localparam logic [2:0] DOS_MODE_PRE_LOCKED = 3'h6;
  localparam logic [2:0] DOS_MODE_PHASE_LOST = 3'h7;
  localparam int DOS_SYNC_STAGES = 2;
endpackage

//--- verilog/dos_sync.sv
// Two-flop synchroniser for a vector of levels.
// Assumes inputs are quasi-static levels from outside ref_clk.
`timescale 1ns/100ps
module dos_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // dos_sync

//--- verilog/dos_status.sv
// Operating-status register: aux loop lock, soft alarms, main loop state.
// Assumes loop indicators arrive as levels from other clock domains.
//
// What this block does
// R1 - Bit 6 reports aux loop lock: 0 unlocked, 1 locked.
// R2 - Aux lock built from four phase-loss sources gated by shared enables.
// R3 - Coarse phase loss event latches bit 6 low until enable cleared.
// R4 - Software clears coarse enable, reads bit 6, re-enables for current reading.
// R5 - A locked reading is current; no enable toggle needed.
// R6 - Bit 5 high while main loop tracks beyond soft alarm limit.
// R7 - Bit 4 high while aux loop tracks beyond soft alarm limit.
// R8 - Bits 2:0 give main loop state code; 000 and 011 unused.
// R9 - Register at 09 is read-only, bit 3 reads zero.
`timescale 1ns/100ps
module dos_status
  import dos_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register read port
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Aux loop phase-loss sources
  input wire logic aux_fine_phase_loss,
  input wire logic aux_coarse_phase_loss,
  input wire logic aux_no_activity,
  input wire logic aux_freq_limit,
  // Shared detector enables
  input wire logic fine_loss_en,
  input wire logic coarse_loss_en,
  input wire logic no_activity_en,
  input wire logic freq_limit_en,
  // Soft alarms and main loop state
  input wire logic main_loop_freq_soft_alarm,
  input wire logic aux_loop_freq_soft_alarm,
  input wire logic [2:0] main_loop_fsm_state,
  input wire logic sync2k_alarm,
  // Status copy
  output logic [7:0] operating_state_status
);
  // Synchronised pin groups
  logic [3:0] loss_s;
  logic [3:0] en_s;
  logic [2:0] alarm_s;
  logic [2:0] state_s;

  // Named views of the synchronised bits
  logic fine_loss_s;
  logic coarse_loss_s;
  logic no_activity_s;
  logic freq_limit_s;
  logic fine_en_s;
  logic coarse_en_s;
  logic no_activity_en_s;
  logic freq_limit_en_s;
  logic main_alarm_s;
  logic aux_alarm_s;
  logic sync2k_s;

  // Loss terms after their enables
  logic fine_lost;
  logic coarse_lost;
  logic no_activity_lost;
  logic freq_limit_lost;
  logic any_live_loss;

  // Held coarse event
  logic coarse_latched;
  logic next_coarse_latched;

  // Register assembly
  logic aux_loop_locked;
  logic [7:0] next_status;

  // Read path
  logic addr_hit;
  logic [7:0] next_rd_data;

  // Pins cross clock domains: two flops before any logic
  dos_sync #(.WIDTH(4), .RESET_VAL(4'h0)) u_sync_loss (
    .ref_clk(ref_clk), .rstn(rstn),
    .async_in({aux_fine_phase_loss, aux_coarse_phase_loss, aux_no_activity, aux_freq_limit}),
    .sync_out(loss_s)
  );
  dos_sync #(.WIDTH(4), .RESET_VAL(4'h0)) u_sync_en (
    .ref_clk(ref_clk), .rstn(rstn),
    .async_in({fine_loss_en, coarse_loss_en, no_activity_en, freq_limit_en}),
    .sync_out(en_s)
  );
  dos_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_sync_alarm (
    .ref_clk(ref_clk), .rstn(rstn),
    .async_in({main_loop_freq_soft_alarm, aux_loop_freq_soft_alarm, sync2k_alarm}),
    .sync_out(alarm_s)
  );
  dos_sync #(.WIDTH(3), .RESET_VAL(DOS_MODE_FREE_RUN)) u_sync_state (
    .ref_clk(ref_clk), .rstn(rstn),
    .async_in(main_loop_fsm_state),
    .sync_out(state_s)
  );

  // Loss detector outputs, high means loss
  assign fine_loss_s = loss_s[3];
  assign coarse_loss_s = loss_s[2];
  assign no_activity_s = loss_s[1];
  assign freq_limit_s = loss_s[0];

  // Detector enables shared with the main loop
  assign fine_en_s = en_s[3];
  assign coarse_en_s = en_s[2];
  assign no_activity_en_s = en_s[1];
  assign freq_limit_en_s = en_s[0];

  // Live alarm levels
  assign main_alarm_s = alarm_s[2];
  assign aux_alarm_s = alarm_s[1];
  assign sync2k_s = alarm_s[0];

  // Each source counts only while its detector is enabled
  always_comb begin
    fine_lost = fine_loss_s && fine_en_s; // [R2]
    coarse_lost = coarse_loss_s && coarse_en_s; // [R2]
    no_activity_lost = no_activity_s && no_activity_en_s; // [R2]
    freq_limit_lost = freq_limit_s && freq_limit_en_s; // [R2]
  end

  // Live sources only; the held coarse event joins below
  always_comb begin
    any_live_loss = fine_lost ||
                    coarse_lost ||
                    no_activity_lost ||
                    freq_limit_lost; // [R2]
  end

  // Coarse loss is sticky; only clearing its enable or a reset releases it.
  // Enable low wins over a new event: a disabled detector cannot re-arm.
  // Trade-off: software loses the history once it clears the enable.
  always_comb begin
    next_coarse_latched = coarse_latched;
    if (!coarse_en_s) begin
      next_coarse_latched = 1'b0; // [R3]
    end else if (coarse_lost) begin
      next_coarse_latched = 1'b1; // [R3]
    end
  end

  // Reset forgets any earlier slip
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      coarse_latched <= 1'b0;
    end else begin
      coarse_latched <= next_coarse_latched; // [R3]
    end
  end

  // Lock falls on any live loss or on the held coarse event
  always_comb begin
    aux_loop_locked = !(any_live_loss || coarse_latched); // [R1] [R2]
  end

  // Field by field; bit 7 passes the sync alarm straight through
  always_comb begin
    next_status = 8'h00;
    next_status[DOS_BIT_SYNC2K] = sync2k_s;
    next_status[DOS_BIT_AUX_LOCKED] = aux_loop_locked; // [R1]
    next_status[DOS_BIT_MAIN_SOFT_ALARM] = main_alarm_s; // [R6]
    next_status[DOS_BIT_AUX_SOFT_ALARM] = aux_alarm_s; // [R7]
    next_status[DOS_BIT_UNUSED] = 1'b0; // [R9]
    next_status[DOS_FSM_MSB:DOS_FSM_LSB] = state_s; // [R8]
  end

  // Unused state codes pass as seen; the loop owns its encoding.
  // A multi-bit code change may show one mixed value for a cycle.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      operating_state_status <= DOS_RESET_VALUE;
    end else begin
      operating_state_status <= next_status;
    end
  end

  // Only one address decodes; writes have no path here
  always_comb begin
    addr_hit = (rd_addr == DOS_ADDR_OPERATING_STATE_STATUS); // [R9]
  end

  // Other addresses read as zero
  always_comb begin
    next_rd_data = 8'h00;
    if (addr_hit) begin
      next_rd_data = operating_state_status; // [R9]
    end
  end

  // One valid pulse per accepted read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
    end
  end

  // Data holds between reads so a slow master may take it late
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= next_rd_data; // [R9]
    end
  end
endmodule // dos_status

//--- dv/dos_status_monitor.sv
// Port checker for dos_status.
// Assumes the bind below connects every port by name.
`timescale 1ns/100ps
module dos_status_monitor (
  input wire logic ref_clk, rstn, rd_en, rd_valid, main_loop_freq_soft_alarm,
  input wire logic aux_fine_phase_loss, fine_loss_en, aux_coarse_phase_loss, coarse_loss_en,
  input wire logic [7:0] rd_addr, rd_data, operating_state_status,
  input wire logic [2:0] main_loop_fsm_state
);
  wire logic [7:0] s = operating_state_status;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_vld; rd_en |=> rd_valid; endproperty
  a_vld: assert property (p_vld) else $error("no valid");
  property p_dat; rd_en && rd_addr == 8'h09 |=> rd_data == $past(s); endproperty
  a_dat: assert property (p_dat) else $error("bad data");
  property p_idle; !rd_en |=> !rd_valid; endproperty
  a_idle: assert property (p_idle) else $error("stray valid");
  property p_hold; !rd_en |=> $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_ref; rd_en && rd_addr != 8'h09 |=> rd_data == 8'h00; endproperty
  a_ref: assert property (p_ref) else $error("bad refuse");
  property p_b3; s[3] == 1'b0; endproperty
  a_b3: assert property (p_b3) else $error("bit 3 set");
  property p_alm; $stable(main_loop_freq_soft_alarm)[*4] |-> s[5] == main_loop_freq_soft_alarm;
  endproperty
  a_alm: assert property (p_alm) else $error("bad alarm");
  property p_fsm; $stable(main_loop_fsm_state)[*4] |-> s[2:0] == main_loop_fsm_state; endproperty
  a_fsm: assert property (p_fsm) else $error("bad state");
  property p_lost; (aux_fine_phase_loss && fine_loss_en)[*4] |-> !s[6]; endproperty
  a_lost: assert property (p_lost) else $error("lock kept");
  // Enable must be settled through its synchroniser before the event
  property p_lat;
    coarse_loss_en[*3] ##0 aux_coarse_phase_loss ##1 coarse_loss_en[*5] |-> !s[6];
  endproperty
  a_lat: assert property (p_lat) else $error("no latch");
  c_rd: cover property (rd_valid);
  c_bad: cover property (rd_en && rd_addr != 8'h09);
  c_unl: cover property ($fell(s[6]));
  c_b2b: cover property (rd_en ##1 rd_en);
endmodule // dos_status_monitor
bind dos_status dos_status_monitor u_dos_status_monitor (.*);

//--- dv/tb.sv
// Table-driven bench for dos_status.
// Assumes the checker is bound in; inputs change 1 ns after the edge.
`timescale 1ns/100ps
module tb;
  logic ref_clk = 0, rstn = 0, rd_en = 0, rd_valid;
  logic [7:0] rd_addr = 8'h00, rd_data, operating_state_status;
  logic [15:0] v = 16'h040F;
  int n_mismatch = 0, num_checks = 0;
  // Row: loop inputs in the upper bits, expected status in the low byte
  logic [23:0] tv[17] = '{24'h040F41, 24'h080F42, 24'h100F44, 24'h140F45, 24'h180F46,
    24'h1C0F47, 24'h1E0F67, 24'h1F0F77, 24'h1D0F57, 24'h1C8F07, 24'h1C8747, 24'h1C2F07,
    24'h1C1F07, 24'h1C4F07, 24'h1C0F07, 24'h1C0B47, 24'h1C0F47};
  dos_status u_dos_status (.*, .sync2k_alarm(1'b0), .main_loop_fsm_state(v[12:10]),
    .main_loop_freq_soft_alarm(v[9]), .aux_loop_freq_soft_alarm(v[8]),
    .aux_fine_phase_loss(v[7]), .aux_coarse_phase_loss(v[6]), .aux_no_activity(v[5]),
    .aux_freq_limit(v[4]), .fine_loss_en(v[3]), .coarse_loss_en(v[2]),
    .no_activity_en(v[1]), .freq_limit_en(v[0]));
  initial forever #25 ref_clk = ~ref_clk;
  task chk(input logic [8:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Four edges first so input changes clear the synchronisers
  task rd(input logic [7:0] a, e);
    repeat (4) @(posedge ref_clk);
    #1 rd_addr = a;
    rd_en = 1;
    @(posedge ref_clk);
    #1 rd_en = 0;
    chk({rd_valid, rd_data}, {1'b1, e});
  endtask
  // Back-to-back reads, then the idle cycle in which data must hold
  task rd_pair(input logic [7:0] e);
    @(posedge ref_clk);
    #1 rd_addr = 8'h0A;
    rd_en = 1;
    @(posedge ref_clk);
    #1 rd_addr = 8'h09;
    chk({rd_valid, rd_data}, 9'h100);
    @(posedge ref_clk);
    #1 rd_en = 0;
    chk({rd_valid, rd_data}, {1'b1, e});
    @(posedge ref_clk);
    #1 chk({rd_valid, rd_data}, {1'b0, e});
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000 n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1;
    rd(8'h0A, 8'h00);
    foreach (tv[i]) begin
      v = tv[i][23:8];
      rd(8'h09, tv[i][7:0]);
      chk({1'b0, operating_state_status}, {1'b0, tv[i][7:0]});
      $display("test %0d done", i);
    end
    rd_pair(8'h47);
    $display("test pair done");
    @(posedge ref_clk);
    #1 rstn = 0;
    #1 chk({rd_valid, rd_data}, 9'h000);
    chk({1'b0, operating_state_status}, 9'h041);
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1;
    rd(8'h09, 8'h47);
    $display("test reset done");
    end_sim;
  end
endmodule // tb
